// ---- bench/adcsr_host_model.sv ----
// adcsr_host_model: host serial port plus upstream converter on chain input
// assumes the bench resolves the shared status pin from its enable
`timescale 1ns/1ps
`default_nettype none
module adcsr_host_model (
  output logic      o_select_n,
  output logic      o_sclk,
  output logic      o_chain_bit,
  output logic      o_oe_ok,
  input  wire logic i_ser_out,
  input  wire logic i_ser_out_oe_n
);
  initial begin
    o_select_n = 1'b1;
    o_sclk = 1'b0;
    o_chain_bit = 1'b0;
    o_oe_ok = 1'b1;
  end
  // one frame of n clocks; up is upstream stream, got is msb aligned
  task automatic frame(input int n, input logic [47:0] up,
                       output logic [47:0] got);
    got = '0;
    o_chain_bit = up[47];
    o_select_n = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      got[47-i] = i_ser_out;
      if (i_ser_out_oe_n !== 1'b0) o_oe_ok = 1'b0;
      o_sclk = 1'b1;
      #62.5;
      o_sclk = 1'b0;
      if (i < 47) o_chain_bit = up[46-i];
      #62.5;
    end
    o_select_n = 1'b1;
    o_chain_bit = ~o_chain_bit;  // released line shows stale inverse
    #60;
    if (i_ser_out_oe_n !== 1'b1) o_oe_ok = 1'b0;
  endtask : frame
endmodule : adcsr_host_model
`default_nettype wire

// ---- bench/tb.sv ----
// tb: self-checking bench of the serial readout block
// assumes adcsr_host_model on the link and a 200 MHz core clock
`timescale 1ns/1ps
`default_nettype none
`include "adcsr_defs.svh"
module tb import adcsr_pkg::*; ;
  logic        clk, rst_n, pin_n, chain, tag, sw_wr, sw_wd, eoc, r_valid;
  logic [15:0] r_data;
  logic [2:0]  r_chan;
  logic        sel_n, sclk, up_bit, oe_ok, st_out, st_oe_n, st_wire;
  logic        ser_out, ser_out_oe_n, soft_bit, cfg_rdy, r_ready;
  logic [47:0] got;
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;
  adcsr_chain adcsr_chain_inst (.i_ref_clk(clk), .i_resetn(rst_n),
    .i_frame_select_n(sel_n), .i_serial_clock(sclk),
    .i_reset_pin_n(pin_n), .i_status_pin(st_wire), .o_status_pin(st_out),
    .o_status_oe_n(st_oe_n), .o_serial_out(ser_out),
    .o_serial_out_oe_n(ser_out_oe_n), .i_chain_mode_select(chain),
    .i_tag_output_enable(tag), .i_soft_reset_write(sw_wr),
    .i_soft_reset_wdata(sw_wd), .o_soft_reset_bit(soft_bit),
    .o_config_ready(cfg_rdy), .i_end_of_conversion(eoc),
    .i_result_valid(r_valid), .o_result_ready(r_ready),
    .i_result_data(r_data), .i_result_chan(r_chan));
  adcsr_host_model adcsr_host_model_inst (.o_select_n(sel_n),
    .o_sclk(sclk), .o_chain_bit(up_bit), .o_oe_ok(oe_ok),
    .i_ser_out(ser_out), .i_ser_out_oe_n(ser_out_oe_n));
  assign st_wire = st_oe_n ? up_bit : st_out;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [47:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic push(input adcsr_result_t r);
    @(posedge clk);
    r_valid <= 1'b1;
    r_data <= r.data;
    r_chan <= r.chan;
    for (int k = 0; k < 50; k++) begin
      @(negedge clk);
      if (r_ready === 1'b1) break;
    end
    chk("push ready", 48'(r_ready), 48'h1);
    @(posedge clk);
    r_valid <= 1'b0;
  endtask : push
  task automatic rd(input int n, input logic [47:0] up, exp,
                    input string what);
    @(posedge clk);
    #1;
    adcsr_host_model_inst.frame(n, up, got);
    chk(what, got, exp);
    chk("serial out enable", 48'(oe_ok), 48'h1);
  endtask : rd
  task automatic wait_rdy();
    for (int k = 0; k < 1000; k++) begin
      @(negedge clk);
      if (cfg_rdy === 1'b1) break;
    end
    chk("config ready", 48'(cfg_rdy), 48'h1);
  endtask : wait_rdy
  task automatic t_power_on();
    repeat (300) @(posedge clk);
    @(negedge clk);
    chk("recovery", 48'(cfg_rdy), 48'h0);
    wait_rdy();
    chk("soft bit", 48'(soft_bit), 48'h1);
    chk("idle oe", 48'(ser_out_oe_n), 48'h1);
    rd(16, '0, {16'hffff, 32'h0}, "first read");
    $display("test power_on done");
  endtask : t_power_on
  task automatic t_regular();
    @(posedge clk);
    tag <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      push({16'ha5c0 + 16'(c), 3'(c)});
      rd(24, '0, {16'ha5c0 + 16'(c), 3'(c), 29'h0}, "tagged");
    end
    @(posedge clk);
    tag <= 1'b0;
    push({16'h3c96, 3'h2});
    rd(24, '0, {16'h3c96, 32'h0}, "untagged");
    $display("test regular done");
  endtask : t_regular
  task automatic t_chain();
    @(posedge clk);
    chain <= 1'b1;
    push({16'h5a0f, 3'h1});
    rd(48, {16'hc3a5, 32'h0ff0_0000}, {48'h5a0f_c3a5_0ff0},
       "chain");
    @(negedge clk);
    chk("status dir", 48'(st_oe_n), 48'h1);
    @(posedge clk);
    tag <= 1'b1;
    push({16'h9e31, 3'h6});
    rd(48, {48'hc3a5_0ff0_1111}, {16'h9e31, 3'h6, 5'h0, 24'hc3a50f},
       "chain tag");
    rd(19, '0, {16'h9e31, 3'h6, 29'h0}, "chain 19");
    @(posedge clk);
    tag <= 1'b0;
    rd(16, {16'hc3a5, 32'h0}, {16'h9e31, 32'h0}, "toggle a");
    rd(16, {16'h0ff0, 32'h0}, {16'h9e31, 32'h0}, "toggle b");
    $display("test chain done");
  endtask : t_chain
  task automatic t_fifo();
    @(posedge clk);
    chain <= 1'b0;
    for (int k = 0; k < 16; k++) push({16'h7000 + 16'(k), 3'h0});
    @(negedge clk);
    chk("fifo full", 48'(r_ready), 48'h0);
    for (int k = 0; k < 16; k++)
      rd(16, '0, {16'h7000 + 16'(k), 32'h0}, "drain");
    rd(16, '0, {16'h700f, 32'h0}, "repeat");
    $display("test fifo done");
  endtask : t_fifo
  task automatic t_soft();
    @(posedge clk);
    sw_wr <= 1'b1;
    sw_wd <= 1'b0;
    @(posedge clk);
    sw_wr <= 1'b0;
    sw_wd <= 1'b1;
    @(negedge clk);
    chk("soft bit low", 48'(soft_bit), 48'h0);
    chk("soft busy", 48'(cfg_rdy), 48'h0);
    wait_rdy();
    chk("soft bit back", 48'(soft_bit), 48'h1);
    rd(16, '0, {16'hffff, 32'h0}, "after soft");
    $display("test soft done");
  endtask : t_soft
  task automatic t_ext();
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    pin_n <= 1'b1;
    repeat (4) @(negedge clk);
    chk("ext busy", 48'(cfg_rdy), 48'h0);
    wait_rdy();
    rd(16, '0, {16'hffff, 32'h0}, "after ext");
    @(posedge clk);
    eoc <= 1'b1;
    repeat (3) @(negedge clk);
    chk("status drive", 48'(st_oe_n), 48'h0);
    chk("status high", 48'(st_out), 48'h1);
    @(posedge clk);
    eoc <= 1'b0;
    repeat (3) @(negedge clk);
    chk("status low", 48'(st_out), 48'h0);
    $display("test ext done");
  endtask : t_ext
  initial begin
    rst_n = 1'b0;
    pin_n = 1'b1;
    {chain, tag, sw_wr, eoc, r_valid} = '0;
    sw_wd = 1'b1;
    r_data = '0;
    r_chan = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_power_on();
    t_regular();
    t_chain();
    t_fifo();
    t_soft();
    t_ext();
    wrap_up();
  end
endmodule : tb
`default_nettype wire

// ---- logic/adcsr_chain.sv ----
// adcsr_chain: serial readout, daisy-chain pass-through and reset sources
// assumes conversion results arrive on the core clock; select, serial
// clock, chain input and reset pin are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
`include "adcsr_defs.svh"
module adcsr_chain
  import adcsr_pkg::*;
#(
  parameter int FIFO_DEPTH = `ADCSR_FIFO_DEPTH
) (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_resetn,
  input  wire logic                        i_frame_select_n,
  input  wire logic                        i_serial_clock,
  input  wire logic                        i_reset_pin_n,
  input  wire logic                        i_status_pin,
  output logic                             o_status_pin,
  output logic                             o_status_oe_n,
  output logic                             o_serial_out,
  output logic                             o_serial_out_oe_n,
  input  wire logic                        i_chain_mode_select,
  input  wire logic                        i_tag_output_enable,
  input  wire logic                        i_soft_reset_write,
  input  wire logic                        i_soft_reset_wdata,
  output logic                             o_soft_reset_bit,
  output logic                             o_config_ready,
  input  wire logic                        i_end_of_conversion,
  input  wire logic                        i_result_valid,
  output logic                             o_result_ready,
  input  wire logic [`ADCSR_WORD_BITS-1:0] i_result_data,
  input  wire logic [`ADCSR_TAG_BITS-1:0]  i_result_chan
);
  localparam int FB = `ADCSR_FRAME_BITS;
  localparam int WB = `ADCSR_WORD_BITS;
  localparam int EXT_CYC = `ADCSR_EXT_RST_CYC;
  localparam int REC_CYC = `ADCSR_RECOVER_CYC;
  localparam int SOFT_CYC = `ADCSR_SOFT_RST_CYC;
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("fifo depth too small");
  end
  default clocking dclk @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  // pin synchronisers: cs, sclk, chain/status input, reset pin
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic       sclk_d_reg;
  logic       cs_d_reg;
  wire        cs_s   = sync2_reg[3];
  wire        sclk_s = sync2_reg[2];
  wire        chin_s = sync2_reg[1];
  wire        rpin_s = sync2_reg[0];
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_reg  <= `ADCSR_SYNC_RST_VAL;
      sync2_reg  <= `ADCSR_SYNC_RST_VAL;
      sclk_d_reg <= 1'b0;
      cs_d_reg   <= 1'b1;
    end else begin
      sync1_reg  <= {i_frame_select_n, i_serial_clock, i_status_pin,
                     i_reset_pin_n};
      sync2_reg  <= sync1_reg;
      sclk_d_reg <= sclk_s;
      cs_d_reg   <= cs_s;
    end
  end
  wire frame_start = cs_d_reg && !cs_s;
  wire frame_end   = !cs_d_reg && cs_s;
  wire sclk_rise   = sclk_s && !sclk_d_reg && !cs_s;

  // reset sources: power-on via i_resetn, software bit, external pin
  adcsr_rst_state_t rst_state_reg;
  adcsr_rst_state_t rst_state_next;
  logic [8:0]       rst_cnt_reg;
  logic [8:0]       rst_cnt_next;
  logic [2:0]       ext_cnt_reg;
  logic             soft_bit_reg;
  wire ext_hit  = !rpin_s && (ext_cnt_reg == 3'(EXT_CYC - 1));
  wire soft_hit = i_soft_reset_write && !i_soft_reset_wdata;
  wire int_rst  = ext_hit || (rst_state_reg == ADCSR_SOFT);
  always_comb begin
    rst_state_next = rst_state_reg;
    rst_cnt_next   = rst_cnt_reg;
    case (rst_state_reg)
      ADCSR_RUN: begin
        rst_cnt_next = '0;
      end
      ADCSR_SOFT: begin
        rst_cnt_next = rst_cnt_reg + 9'd1;
        if (rst_cnt_reg == 9'(SOFT_CYC - 1)) begin
          rst_state_next = ADCSR_RECOVER;
          rst_cnt_next   = '0;
        end
      end
      ADCSR_RECOVER: begin
        rst_cnt_next = rst_cnt_reg + 9'd1;
        if (rst_cnt_reg == 9'(REC_CYC - 1)) rst_state_next = ADCSR_RUN;
      end
      default: rst_state_next = ADCSR_RUN;
    endcase
    if (soft_hit) begin
      rst_state_next = ADCSR_SOFT;
      rst_cnt_next   = '0;
    end else if (ext_hit) begin
      rst_state_next = ADCSR_RECOVER;
      rst_cnt_next   = '0;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_state_reg <= ADCSR_RECOVER;
      rst_cnt_reg   <= '0;
      ext_cnt_reg   <= '0;
      soft_bit_reg  <= 1'b1;
    end else begin
      rst_state_reg <= rst_state_next;
      rst_cnt_reg   <= rst_cnt_next;
      if (rpin_s) ext_cnt_reg <= '0;
      else if (ext_cnt_reg != 3'(EXT_CYC)) ext_cnt_reg <= ext_cnt_reg + 3'd1;
      if (soft_hit) soft_bit_reg <= 1'b0;
      else if (rst_state_reg == ADCSR_SOFT && rst_state_next != ADCSR_SOFT)
        soft_bit_reg <= 1'b1;
    end
  end
  assign o_soft_reset_bit = soft_bit_reg;
  assign o_config_ready   = (rst_state_reg == ADCSR_RUN);

  // result buffer between conversion core and readout
  adcsr_result_t fifo_out;
  logic          fifo_valid;
  wire           fifo_pop = frame_start && !int_rst;
  adcsr_fifo #(
    .WIDTH ($bits(adcsr_result_t)),
    .DEPTH (FIFO_DEPTH)
  ) adcsr_fifo_inst (
    .i_ref_clk   (i_ref_clk),
    .i_resetn    (i_resetn),
    .i_clear     (int_rst),
    .i_in_valid  (i_result_valid),
    .o_in_ready  (o_result_ready),
    .i_in_data   ({i_result_data, i_result_chan}),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_out)
  );

  // output register and frame assembly
  adcsr_cfg_t    cfg;
  adcsr_result_t last_reg;
  adcsr_result_t own;
  logic [FB-1:0] shift_reg;
  logic          first_reg;
  logic          oe_n_reg;
  logic          status_reg;
  assign cfg.chain_mode_select = i_chain_mode_select;
  assign cfg.tag_output_enable = i_tag_output_enable;
  assign own = fifo_valid ? fifo_out : last_reg;
  wire [FB-1:0] load_word = first_reg ? {FB{1'b1}} :
    (cfg.tag_output_enable ? {own.data, own.chan, 5'h00}
                           : {own.data, 8'h00});
  wire [FB-1:0] shifted = {shift_reg[FB-2:0], 1'b0};
  wire          chain_bit = cfg.chain_mode_select && chin_s;
  wire [FB-1:0] ins_mask = cfg.tag_output_enable ? 24'h000001 : 24'h000100;
  wire [FB-1:0] shift_in = chain_bit ? (shifted | ins_mask)
                                     : (shifted & ~ins_mask);
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      last_reg   <= '0;
      shift_reg  <= '0;
      first_reg  <= 1'b1;
      oe_n_reg   <= 1'b1;
      status_reg <= 1'b0;
    end else if (int_rst) begin
      last_reg   <= '0;
      shift_reg  <= '0;
      first_reg  <= 1'b1;
      oe_n_reg   <= 1'b1;
      status_reg <= 1'b0;
    end else begin
      oe_n_reg   <= cs_s;
      status_reg <= i_end_of_conversion;
      if (frame_start) begin
        shift_reg <= load_word;
        if (fifo_valid) last_reg <= fifo_out;
      end else if (sclk_rise) begin
        shift_reg <= shift_in;
      end
      if (frame_end) first_reg <= 1'b0;
    end
  end
  assign o_serial_out      = shift_reg[FB-1];
  assign o_serial_out_oe_n = oe_n_reg;
  assign o_status_pin      = status_reg;
  assign o_status_oe_n     = cfg.chain_mode_select;

  localparam int SOFT_MAX = `ADCSR_SOFT_RST_CYC + 1;
  oe_release_a: assert property (
    (cs_s && !int_rst) |=> o_serial_out_oe_n)
    else $error("serial out driven with select high");
  ones_first_a: assert property (
    (frame_start && first_reg && !int_rst) |=> (shift_reg == {FB{1'b1}}))
    else $error("first frame after reset not all ones");
  own_word_a: assert property (
    (frame_start && !first_reg && !int_rst)
      |=> (shift_reg[FB-1:FB-WB] == last_reg.data))
    else $error("first word is not own result");
  chain_pass_a: assert property (
    (sclk_rise && !frame_start && !int_rst && cfg.chain_mode_select)
      |=> (shift_reg[$past(cfg.tag_output_enable) ? 0 : 8] == $past(chin_s)))
    else $error("chain bit not captured");
  tag_bits_a: assert property (
    (frame_start && !first_reg && !int_rst && cfg.tag_output_enable)
      |=> (shift_reg[7:0] == {last_reg.chan, 5'h00}))
    else $error("tag bits or zero fill wrong");
  no_trail_a: assert property (
    (frame_start && !first_reg && !int_rst && !cfg.tag_output_enable)
      |=> (shift_reg[7:0] == 8'h00))
    else $error("trailing bits present with tags off");
  soft_back_a: assert property (
    $fell(o_soft_reset_bit) |-> ##[1:SOFT_MAX] o_soft_reset_bit)
    else $error("software reset bit did not return to one");
  ext_reset_a: assert property (
    ext_hit |=> (first_reg && !o_config_ready && shift_reg == '0))
    else $error("external reset did not restore default state");
  recover_a: assert property (
    $rose(o_config_ready) |-> $past(rst_state_reg) == ADCSR_RECOVER)
    else $error("ready without recovery wait");
  prev_result_a: assert property (
    (frame_start && !fifo_valid && !int_rst) |=> $stable(last_reg))
    else $error("previous result not kept");
endmodule : adcsr_chain
`default_nettype wire

// ---- logic/adcsr_defs.svh ----
// adcsr_defs.svh: constants of the converter serial readout block
// assumes a 200 MHz core clock; included by its bare name
// Operation
// - chain input passes to serial out after 16 clocks, 24 with tags.
// - first word after select falls is always this converter's own result; the code sends all ones in the first frame after any reset.
// - while select stays low, later words come from converters further upstream.
// - toggling select repeats own result each word; host must avoid it.
// - without a new conversion, the previous result is forwarded.
// - tags off: a read is 16 clocks with no trailing bits.
// - chain and tags on: at least 19 clocks, tags then up to 5 zeros.
// - regular and tags on: 24 clocks, tags then exactly 5 zeros.
// - three reset sources: power-on, software bit, external low pin.
// - power-on reset yields default mode without host commands.
// - writing 0 to software reset bit resets; bit returns to 1 itself.
// - a config bit makes the status pin chain input or end-of-conversion output.
// - with tags, three channel bits follow the result LSB.
// - serial out drives only while select is low.
// - first serial cycle after any reset outputs all ones.
`ifndef ADCSR_DEFS_SVH
`define ADCSR_DEFS_SVH
`define ADCSR_WORD_BITS      16
`define ADCSR_TAG_BITS       3
`define ADCSR_FRAME_BITS     24
`define ADCSR_INS_TAG_ON     0
`define ADCSR_INS_TAG_OFF    8
`define ADCSR_FIFO_DEPTH     16
`define ADCSR_CLK_PERIOD_NS  5
`define ADCSR_EXT_RST_MIN_NS 25
`define ADCSR_EXT_RST_CYC \
  ((`ADCSR_EXT_RST_MIN_NS + `ADCSR_CLK_PERIOD_NS - 1) / `ADCSR_CLK_PERIOD_NS)
`define ADCSR_RECOVER_US     2
`define ADCSR_RECOVER_CYC \
  ((`ADCSR_RECOVER_US * 1000 + `ADCSR_CLK_PERIOD_NS - 1) / `ADCSR_CLK_PERIOD_NS)
`define ADCSR_SOFT_RST_CYC   4
`define ADCSR_SYNC_RST_VAL   4'h9
`endif

// ---- logic/adcsr_fifo.sv ----
// adcsr_fifo: flip-flop FIFO with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module adcsr_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_clear,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
    $error("fifo depth must be a power of two, width positive");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  wire push = i_in_valid && o_in_ready;
  wire pop  = o_out_valid && i_out_ready;
  assign o_in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data  = mem_reg[rd_reg];
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else if (i_clear) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + AW'(1);
      if (pop) rd_reg <= rd_reg + AW'(1);
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (push) mem_reg[wr_reg] <= i_in_data;
  end
endmodule : adcsr_fifo
`default_nettype wire

// ---- logic/adcsr_pkg.sv ----
// adcsr_pkg: types of the converter serial readout block
// assumes adcsr_defs.svh is on the include path
`include "adcsr_defs.svh"
package adcsr_pkg;
  typedef struct packed {
    logic [`ADCSR_WORD_BITS-1:0] data;
    logic [`ADCSR_TAG_BITS-1:0]  chan;
  } adcsr_result_t;
  typedef struct packed {
    logic chain_mode_select;
    logic tag_output_enable;
  } adcsr_cfg_t;
  typedef enum logic [1:0] {
    ADCSR_RUN,
    ADCSR_SOFT,
    ADCSR_RECOVER
  } adcsr_rst_state_t;
endpackage : adcsr_pkg
